//--- common/dts_consts.vh
// Purpose: constants for the DRAM topology host controller
// Assumes: 16K x 4 DRAM, 8 row bits and 6 column bits on 8 shared address pins
// Notes: included by core files only; definitions only
`ifndef DTS_CONSTS_VH
`define DTS_CONSTS_VH
`define DTS_ROW_W 8
`define DTS_COL_W 6
`define DTS_DQ_W 4
`define DTS_IDX_W 8
`define DTS_ROW_HALF_BIT 7
// Access timing in system clock cycles (25 ns each)
`define DTS_T_RAS_CYC 4'h2
`define DTS_T_CAS_CYC 4'h2
`define DTS_T_DATA_CYC 4'h3
`define DTS_T_PRE_CYC 4'h3
// Operation codes
`define DTS_OP_READ 2'h0
`define DTS_OP_WRITE 2'h1
`define DTS_OP_REFRESH 2'h2
`endif

//--- core/dts_neighbour.v
// Purpose: neighbour cell finder for pattern-sensitivity tests
// Assumes: row and cell index as logical addresses, wrap-around at array edges
// Notes: purely combinational; outputs are registered by the caller
`timescale 1ns/1ps
`include "dts_consts.vh"
module dts_neighbour
(
   // Cell under test
   input wire [7:0] row,
   input wire [7:0] cellIndex,
   // Two nearest neighbours, then three near neighbours
   output reg [7:0] nstRow0,
   output reg [7:0] nstIdx0,
   output reg [7:0] nstRow1,
   output reg [7:0] nstIdx1,
   output reg [7:0] nrRow0,
   output reg [7:0] nrIdx0,
   output reg [7:0] nrRow1,
   output reg [7:0] nrIdx1,
   output reg [7:0] nrRow2,
   output reg [7:0] nrIdx2
);

   reg sameParity;
   reg upperHalf;
   reg [7:0] step1;
   reg [7:0] step2;

   // Cell offsets flip sign in the mirrored upper half; row offsets do not
   always @*
   begin
      sameParity = (row[0] == cellIndex[0]);
      upperHalf = row[`DTS_ROW_HALF_BIT];
      step1 = upperHalf ? 8'hff : 8'h01;
      step2 = upperHalf ? 8'hfe : 8'h02;
      nrRow0 = row - 8'h02;
      nrIdx0 = cellIndex;
      nrRow1 = row + 8'h02;
      nrIdx1 = cellIndex;
      if (sameParity)
      begin
         nstRow0 = row - 8'h02;
         nstIdx0 = cellIndex + step1;
         nstRow1 = row;
         nstIdx1 = cellIndex + step1;
         nrRow2 = row - 8'h01;
         nrIdx2 = cellIndex + step2;
      end
      else
      begin
         nstRow0 = row;
         nstIdx0 = cellIndex - step1;
         nstRow1 = row + 8'h02;
         nstIdx1 = cellIndex - step1;
         nrRow2 = row + 8'h01;
         nrIdx2 = cellIndex - step2;
      end
   end
endmodule

//--- core/dts_host.v
// Purpose: host controller driving a 16K x 4 DRAM with topology scrambling
// Assumes: single 40 MHz clock, asynchronous active-high reset
// Notes: one access at a time; requests while busy are refused via reqReady
`timescale 1ns/1ps
`include "dts_consts.vh"
module dts_host
(
   // Clock and reset
   input wire clk_sys,
   input wire reset,
   // Request port
   input wire reqValid,
   output wire reqReady,
   input wire [1:0] reqOp,
   input wire [7:0] reqRow,
   input wire [5:0] reqCol,
   input wire [3:0] reqWrData,
   input wire mux7x7,
   // Answer port
   output reg rspValid_r,
   output reg [3:0] rspRdData_r,
   // Neighbour query, answered one cycle later
   input wire nbrValid,
   input wire [7:0] nbrRow,
   input wire [7:0] nbrCellIndex,
   output reg nbrDone_r,
   output reg [79:0] nbrCells_r,
   // Seven-bit refresh counter from a processor
   input wire [6:0] cpuRefresh,
   // DRAM pins
   output reg [7:0] addrPins_r,
   output reg rasN_r,
   output reg casN_r,
   output reg weN_r,
   output reg outEnN_r,
   input wire [3:0] dqIn,
   output reg [3:0] dqOut_r,
   output reg dqOeN_r
);

   // ********************************************************
   // States
   // ********************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_RAS = 3'h1;
   localparam ST_CAS = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_PRE = 3'h4;

   reg [2:0] state_r;
   reg [3:0] cnt_r;
   reg [1:0] op_r;
   reg [7:0] row_r;
   reg [5:0] col_r;
   reg [3:0] wrData_r;
   reg invert_r;
   reg [7:0] refRow_r;
   reg cpuRefMsb_r;
   reg [6:0] cpuRefLast_r;
   reg [3:0] dqMeta_r;
   reg [3:0] dqSync_r;
   wire [79:0] nbrCells;

   // Column onto pins 1..6; pins 0 and 7 carry no weight, or line seven in 7x7 mode
   function [7:0] colPins;
      input [5:0] col;
      input [7:0] row;
      input mode7;
      begin
         colPins = {1'b0, col, 1'b0};
         if (mode7)
            colPins[0] = row[`DTS_ROW_HALF_BIT];
      end
   endfunction

   // Four data bits flipped together for the inverted half
   function [3:0] fixData;
      input [3:0] d;
      input inv;
      begin
         fixData = inv ? ~d : d;
      end
   endfunction

   assign reqReady = (state_r == ST_IDLE);

   // ********************************************************
   // Neighbour finder
   // ********************************************************
   dts_neighbour uNbr
   (
      .row(nbrRow),
      .cellIndex(nbrCellIndex),
      .nstRow0(nbrCells[79:72]),
      .nstIdx0(nbrCells[71:64]),
      .nstRow1(nbrCells[63:56]),
      .nstIdx1(nbrCells[55:48]),
      .nrRow0(nbrCells[47:40]),
      .nrIdx0(nbrCells[39:32]),
      .nrRow1(nbrCells[31:24]),
      .nrIdx1(nbrCells[23:16]),
      .nrRow2(nbrCells[15:8]),
      .nrIdx2(nbrCells[7:0])
   );

   // Register neighbour answers so data outputs come from flip-flops
   always @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         nbrDone_r <= 1'b0;
         nbrCells_r <= 80'h0;
      end
      else
      begin
         nbrDone_r <= nbrValid;
         if (nbrValid)
            nbrCells_r <= nbrCells;
      end
   end

   // Read data comes from the pins, so two flops before use
   always @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         dqMeta_r <= 4'h0;
         dqSync_r <= 4'h0;
      end
      else
      begin
         dqMeta_r <= dqIn;
         dqSync_r <= dqMeta_r;
      end
   end

   // ********************************************************
   // Refresh row extension
   // ********************************************************
   // A 7-bit counter wraps every 128 rows; toggle the top bit on each wrap
   always @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cpuRefLast_r <= 7'h0;
         cpuRefMsb_r <= 1'b0;
      end
      else
      begin
         cpuRefLast_r <= cpuRefresh;
         if (cpuRefresh == 7'h00 && cpuRefLast_r == 7'h7f)
            cpuRefMsb_r <= ~cpuRefMsb_r;
      end
   end

   // ********************************************************
   // Access sequencer
   // ********************************************************
   // Output enable stays high until the data phase of a read, so the
   // memory never fights our write drivers on the shared lines
   always @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         op_r <= 2'h0;
         row_r <= 8'h0;
         col_r <= 6'h0;
         wrData_r <= 4'h0;
         invert_r <= 1'b0;
         refRow_r <= 8'h0;
         addrPins_r <= 8'h0;
         rasN_r <= 1'b1;
         casN_r <= 1'b1;
         weN_r <= 1'b1;
         outEnN_r <= 1'b1;
         dqOut_r <= 4'h0;
         dqOeN_r <= 1'b1;
         rspValid_r <= 1'b0;
         rspRdData_r <= 4'h0;
      end
      else
      begin
         rspValid_r <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (reqValid)
               begin
                  op_r <= reqOp;
                  col_r <= reqCol;
                  wrData_r <= reqWrData;
                  cnt_r <= `DTS_T_RAS_CYC;
                  state_r <= ST_RAS;
                  rasN_r <= 1'b0;
                  if (reqOp == `DTS_OP_REFRESH)
                  begin
                     // Own counter or extended processor count, full 8 bits
                     row_r <= mux7x7 ? {cpuRefMsb_r, cpuRefresh} : refRow_r;
                     addrPins_r <= mux7x7 ? {cpuRefMsb_r, cpuRefresh} : refRow_r;
                     refRow_r <= refRow_r + 8'h01;
                  end
                  else
                  begin
                     row_r <= reqRow;
                     addrPins_r <= reqRow;
                     invert_r <= ~reqRow[`DTS_ROW_HALF_BIT];
                  end
               end
            end
            ST_RAS:
            begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
               begin
                  if (op_r == `DTS_OP_REFRESH)
                  begin
                     cnt_r <= `DTS_T_DATA_CYC; // RAS-only refresh
                     state_r <= ST_DATA;
                  end
                  else
                  begin
                     addrPins_r <= colPins(col_r, row_r, mux7x7);
                     cnt_r <= `DTS_T_CAS_CYC;
                     state_r <= ST_CAS;
                     if (op_r == `DTS_OP_WRITE)
                     begin
                        dqOut_r <= fixData(wrData_r, invert_r);
                        dqOeN_r <= 1'b0;
                     end
                  end
               end
            end
            ST_CAS:
            begin
               casN_r <= 1'b0;
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
               begin
                  if (op_r == `DTS_OP_WRITE)
                     weN_r <= 1'b0;
                  else
                     outEnN_r <= 1'b0;
                  cnt_r <= `DTS_T_DATA_CYC;
                  state_r <= ST_DATA;
               end
            end
            ST_DATA:
            begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
               begin
                  if (op_r == `DTS_OP_READ)
                     rspRdData_r <= fixData(dqSync_r, invert_r);
                  rspValid_r <= 1'b1;
                  rasN_r <= 1'b1;
                  casN_r <= 1'b1;
                  weN_r <= 1'b1;
                  outEnN_r <= 1'b1;
                  dqOeN_r <= 1'b1;
                  cnt_r <= `DTS_T_PRE_CYC;
                  state_r <= ST_PRE;
               end
            end
            ST_PRE:
            begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

//--- tb/dts_dram_model.sv
// Purpose: behavioural 16K x 4 DRAM for the host bench
// Assumes: strobes are active low and come from one controller
// Notes: memory holds charge, so it reads back as system data
`timescale 1ns/1ps
module dts_dram_model
(
   // Strobes and address
   input wire [7:0] addrPins,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire outEnN,
   // Data lines split by direction
   input wire [3:0] dqOut,
   input wire dqOeN,
   output wire [3:0] dqIn
);
   // ****
   // Array
   // ****
   reg [3:0] mem [0:16383];
   reg [7:0] rowL;
   reg [5:0] colL;
   reg [3:0] lastRd = 4'h0;
   wire [3:0] rdWord;
   // Eight row bits, then six column bits from pins 1 to 6
   // Row pins change with the strobe itself, so let them settle before latching
   always @(negedge rasN) #1 rowL = addrPins;
   always @(negedge casN) colL = addrPins[6:1];
   // Late write; low row half stores inverted charge
   always @(negedge weN or negedge casN)
      if (!weN && !casN && !rasN && !dqOeN)
      begin
         mem[{rowL, colL}] = rowL[7] ? dqOut : ~dqOut;
      end
   assign rdWord = rowL[7] ? mem[{rowL, colL}] : ~mem[{rowL, colL}];
   // Released lines show the inverse so stale data never passes
   always @(posedge outEnN) lastRd = rdWord;
   assign dqIn = outEnN ? ~lastRd : rdWord;
endmodule

//--- tb/dts_host_checker.sv
// Purpose: port assertions for dts_host
// Assumes: one clock, async reset
// Notes: bound to every dts_host
`timescale 1ns/1ps
module dts_host_checker
(
   // Watched ports
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic [1:0] reqOp,
   input wire logic [7:0] reqRow,
   input wire logic [5:0] reqCol,
   input wire logic [3:0] reqWrData,
   input wire logic mux7x7,
   input wire logic nbrValid,
   input wire logic [7:0] nbrRow,
   input wire logic [7:0] nbrCellIndex,
   input wire logic [79:0] nbrCells_r,
   input wire logic [6:0] cpuRefresh,
   input wire logic [7:0] addrPins_r,
   input wire logic rasN_r,
   input wire logic casN_r,
   input wire logic outEnN_r,
   input wire logic [3:0] dqOut_r,
   input wire logic dqOeN_r
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic [7:0] rowL;
   logic [5:0] colL;
   logic [3:0] datL;
   logic [1:0] opL;
   // Latch the access under way so pins can be judged later
   always @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         rowL <= 8'h00;
         colL <= 6'h00;
         datL <= 4'h0;
         opL <= 2'h0;
      end
      else if (reqValid && reqReady)
      begin
         rowL <= reqRow;
         colL <= reqCol;
         datL <= reqWrData;
         opL <= reqOp;
      end
   sequence s_row_strobe;
      $fell(rasN_r) && opL != 2'h2;
   endsequence
   sequence s_eq_low;
      nbrValid && nbrRow[0] == nbrCellIndex[0] && !nbrRow[7];
   endsequence
   sequence s_ne_high;
      nbrValid && nbrRow[0] != nbrCellIndex[0] && nbrRow[7];
   endsequence
   a_write_data_inv: assert property (!dqOeN_r |->
      dqOut_r == (rowL[7] ? datL : ~datL)) else $error("write data polarity");
   a_no_bus_fight: assert property (!outEnN_r |-> dqOeN_r)
      else $error("host drives during read");
   a_row_on_pins: assert property (s_row_strobe |-> addrPins_r == rowL)
      else $error("row pins wrong");
   a_col_on_pins: assert property ($fell(casN_r) |->
      addrPins_r[6:1] == colL && !addrPins_r[7]) else $error("column pins wrong");
   a_pin_zero_mode: assert property ($fell(casN_r) |->
      addrPins_r[0] == (mux7x7 && rowL[7])) else $error("pin zero wrong");
   a_refresh_row_low: assert property ($fell(rasN_r) && opL == 2'h2 && mux7x7 |->
      addrPins_r[6:0] == cpuRefresh) else $error("refresh row wrong");
   a_nbr_equal_low: assert property (s_eq_low |=> nbrCells_r[79:48] ==
      {$past(nbrRow) - 8'h2, $past(nbrCellIndex) + 8'h1, $past(nbrRow),
      $past(nbrCellIndex) + 8'h1}) else $error("equal parity nearest wrong");
   a_nbr_unequal_high: assert property (s_ne_high |=> nbrCells_r[15:0] ==
      {$past(nbrRow) + 8'h1, $past(nbrCellIndex) + 8'h2}) else $error("far near wrong");
endmodule
bind dts_host dts_host_checker i_chk (.*);

//--- tb/dts_host_bench.sv
// Purpose: self-checking bench for dts_host
// Assumes: 40 MHz clock, DRAM model on the far side
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module dts_host_bench;
   reg clk_sys = 1'b0;
   reg reset = 1'b1;
   reg reqValid = 1'b0;
   reg [1:0] reqOp = 2'h0;
   reg [7:0] reqRow = 8'h00;
   reg [5:0] reqCol = 6'h00;
   reg [3:0] reqWrData = 4'h0;
   reg mux7x7 = 1'b0;
   reg nbrValid = 1'b0;
   reg [7:0] nbrRow = 8'h00;
   reg [7:0] nbrCellIndex = 8'h00;
   reg [6:0] cpuRefresh = 7'h2a;
   wire reqReady, rspValid_r, nbrDone_r, rasN_r, casN_r, weN_r, outEnN_r, dqOeN_r;
   wire [3:0] rspRdData_r, dqIn, dqOut_r;
   wire [79:0] nbrCells_r;
   wire [7:0] addrPins_r;
   integer n_mismatch = 0;
   integer check_count = 0;
   integer i;
   // ****
   // Harness
   // ****
   always #12.5 clk_sys = ~clk_sys;
   dts_host i_dut (.clk_sys(clk_sys), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
      .reqOp(reqOp), .reqRow(reqRow), .reqCol(reqCol), .reqWrData(reqWrData), .mux7x7(mux7x7),
      .rspValid_r(rspValid_r), .rspRdData_r(rspRdData_r), .nbrValid(nbrValid), .nbrRow(nbrRow),
      .nbrCellIndex(nbrCellIndex), .nbrDone_r(nbrDone_r), .nbrCells_r(nbrCells_r),
      .cpuRefresh(cpuRefresh), .addrPins_r(addrPins_r), .rasN_r(rasN_r), .casN_r(casN_r),
      .weN_r(weN_r), .outEnN_r(outEnN_r), .dqIn(dqIn), .dqOut_r(dqOut_r), .dqOeN_r(dqOeN_r));
   dts_dram_model i_mem (.addrPins(addrPins_r), .rasN(rasN_r), .casN(casN_r),
      .weN(weN_r), .outEnN(outEnN_r), .dqOut(dqOut_r), .dqOeN(dqOeN_r), .dqIn(dqIn));
   task check(input [79:0] seen, input [79:0] want);
      begin
         check_count = check_count + 1;
         if (seen !== want)
         begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
         end
      end
   endtask
   // One access; holds the request while it is refused, until ready is seen
   task access(input [1:0] op, input [7:0] r, input [5:0] c, input [3:0] d);
      integer k;
      begin
         @(negedge clk_sys);
         {reqOp, reqRow, reqCol, reqWrData} = {op, r, c, d};
         reqValid = 1'b1;
         while (reqReady !== 1'b1) @(negedge clk_sys);
         @(negedge clk_sys);
         reqValid = 1'b0;
         k = 0;
         while (rspValid_r !== 1'b1 && k < 20)
         begin
            @(negedge clk_sys);
            k = k + 1;
         end
         check(k < 20, 1'b1);
      end
   endtask
   task t_data(input [7:0] r, input [5:0] c, input [3:0] d);
      begin
         access(2'h1, r, c, d);
         access(2'h0, r, c, 4'h0);
         check(rspRdData_r, d);
         check(i_mem.mem[{r, c}], d);
      end
   endtask
   // Neighbours; cell offsets flip sign in the upper half
   function [79:0] nb(input [7:0] r, input [7:0] c);
      reg [7:0] s;
      begin
         s = r[7] ? 8'hff : 8'h01;
         if (r[0] == c[0])
            nb = {r - 8'h2, c + s, r, c + s, r - 8'h2, c, r + 8'h2, c, r - 8'h1, c + s + s};
         else
            nb = {r, c - s, r + 8'h2, c - s, r - 8'h2, c, r + 8'h2, c, r + 8'h1, c - s - s};
      end
   endfunction
   task t_nbr(input [7:0] r, input [7:0] c);
      begin
         @(negedge clk_sys);
         {nbrRow, nbrCellIndex, nbrValid} = {r, c, 1'b1};
         @(negedge clk_sys);
         nbrValid = 1'b0;
         check(nbrDone_r, 1'b1);
         check(nbrCells_r, nb(r, c));
      end
   endtask
   // Refresh row as latched by the memory, all eight bits
   task t_refresh(input [7:0] want);
      begin
         access(2'h2, 8'h00, 6'h00, 4'h0);
         check(i_mem.rowL, want);
      end
   endtask
   // Mid-run reset; strobes return high and the refresh counter restarts
   task t_reset;
      begin
         @(negedge clk_sys);
         reset = 1'b1;
         @(negedge clk_sys);
         check({reqReady, rasN_r, casN_r, weN_r, outEnN_r, dqOeN_r}, 6'h3f);
         repeat (2) @(negedge clk_sys);
         reset = 1'b0;
      end
   endtask
   task close_out;
      begin
         $display("mismatches %0d checks %0d", n_mismatch, check_count);
         if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Watchdog: 8000 cycles, far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      n_mismatch = n_mismatch + 1;
      close_out;
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      // Both halves, edge rows and columns, both multiplex modes
      for (i = 0; i < 8; i = i + 1)
      begin
         mux7x7 = i[2];
         t_data({i[1], {7{i[0]}}}, {6{i[0]}}, i[3:0] ^ 4'ha);
      end
      // Processor count extended: no wrap yet, then one wrap sets the top bit
      t_refresh({1'b0, cpuRefresh});
      @(negedge clk_sys);
      cpuRefresh = 7'h7f;
      @(negedge clk_sys);
      cpuRefresh = 7'h00;
      t_refresh(8'h80);
      // Own counter counts from zero after a reset
      t_reset;
      mux7x7 = 1'b0;
      t_refresh(8'h00);
      t_refresh(8'h01);
      t_nbr(8'h10, 8'h20);
      t_nbr(8'h91, 8'h31);
      t_nbr(8'h00, 8'hff);
      t_nbr(8'hf3, 8'h02);
      close_out;
   end
endmodule
